// File: design/dagc_pkg.sv
// package: constants, register map and carrier types of the dual amplifier gain control port
//
// Contract
// - parallel gain is 26 dB minus 0.25 dB per code, codes above 80 give 6 dB
// - parallel code pins drive the gain path directly, no latch or synchroniser
// - shutdown low enables the amplifier, high disables its high power sections
// - during shutdown the control logic stays alive and keeps the last gain
// - shutdown pin acts only in parallel mode; serial mode uses the power register
// - interface select high chooses serial mode and repurposes four shared pins
// - device is selected only while chip select is low
// - input bits sampled on rising serial clock, output changes on falling edge
// - each chip select assertion starts a new access of exactly 16 clocks
// - chip select released before sixteenth clock discards the access entirely
// - chip select rising edge commits the address and, for writes, the data
// - serial output is undriven unless chip select is asserted
// - addressed register shifts out on the second group of eight falling edges
// - serial output sources current for one, switches off for zero
// - addresses 0 and 1 are read only identity, gain and power are read write
// - after reset power reads 0, both gains read 80, channel control reads 3
// - power register: channel A off bits 5 and 3, channel B 4 and 2
// - gain register holds 7 bit code in bits 6..0, bit 7 reserved
// - tie bit set makes both channels use the channel A gain register
// - channel gain follows its register only while its load bit is one
// - read bit is one for read, zero for write; reserved zero; data ignored on read
package dagc_pkg;

    // frame shape
    localparam int         ADDR_W         = 4;
    localparam logic [4:0] FRAME_BITS     = 5'h10;
    localparam logic [4:0] BYTE_BITS      = 5'h08;
    localparam logic [4:0] LAST_IDX       = 5'h0F;

    // register offsets
    localparam logic [3:0] ADDR_REVISION  = 4'h0;
    localparam logic [3:0] ADDR_PART      = 4'h1;
    localparam logic [3:0] ADDR_POWER     = 4'h2;
    localparam logic [3:0] ADDR_GAIN_A    = 4'h3;
    localparam logic [3:0] ADDR_GAIN_B    = 4'h4;
    localparam logic [3:0] ADDR_CTRL      = 4'h5;

    // values after reset and writable bit masks
    localparam logic [7:0] PWR_RST        = 8'h00;
    localparam logic [7:0] GAIN_RST       = 8'h50;
    localparam logic [7:0] CTRL_RST       = 8'h03;
    localparam logic [7:0] PWR_MASK       = 8'h3C;
    localparam logic [7:0] GAIN_MASK      = 8'h7F;
    localparam logic [7:0] CTRL_MASK      = 8'h07;

    // field positions
    localparam int         PD_A_FIRST     = 5;
    localparam int         PD_B_FIRST     = 4;
    localparam int         PD_A_SECOND    = 3;
    localparam int         PD_B_SECOND    = 2;
    localparam int         TIE_BIT        = 2;
    localparam int         LOAD_A_BIT     = 1;
    localparam int         LOAD_B_BIT     = 0;

    // gain arithmetic in quarter dB steps
    localparam logic [6:0] GAIN_CODE_MAX  = 7'h50;
    localparam logic [6:0] GAIN_QDB_TOP   = 7'h68;
    localparam logic [6:0] GAIN_QDB_FLOOR = 7'h18;

    // one serial frame, msb first
    typedef struct packed {
        logic              read_not_write;
        logic [2:0]        reserved_bit;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } dagc_frame_s;

    // what the link hands to the core
    typedef struct packed {
        dagc_frame_s frame;
        logic        toggle;
    } dagc_xfer_s;

    // link domain state
    typedef struct packed {
        dagc_frame_s       shift;
        logic [4:0]        cnt;
        logic [ADDR_W-1:0] addr;
        logic              toggle;
    } dagc_link_s;

    // core domain state
    typedef struct packed {
        logic       sel1;
        logic       sel2;
        logic       sd1;
        logic       sd2;
        logic       cs1;
        logic       cs2;
        logic       tg1;
        logic       tg2;
        logic       tg_seen;
        logic       pend;
        logic [7:0] pwr;
        logic [7:0] gain_a;
        logic [7:0] gain_b;
        logic [7:0] ctrl;
        logic [6:0] act_a;
        logic [6:0] act_b;
        logic       en_a;
        logic       en_b;
    } dagc_core_s;

    localparam dagc_core_s CORE_RST = '{pwr: PWR_RST, gain_a: GAIN_RST, gain_b: GAIN_RST,
                                        ctrl: CTRL_RST, act_a: GAIN_RST[6:0], act_b: GAIN_RST[6:0],
                                        en_a: 1'b1, en_b: 1'b1, cs1: 1'b1, cs2: 1'b1, default: '0};

endpackage

// File: design/dagc_link.sv
// serial link engine on the host's serial clock: shift, count, address capture, data out
`timescale 1ns/10ps
module dagc_link
    import dagc_pkg::*;
(
    // link pins
    input  wire logic              sclk,
    input  wire logic              rst,
    input  wire logic              cs_n,
    input  wire logic              sdi,
    // register file read port
    input  wire logic [7:0]        rd_byte,
    output logic [ADDR_W-1:0]      rd_addr,
    // finished frame and output bit
    output dagc_xfer_s             xfer,
    output logic                   sdo_bit
);

    dagc_link_s st_r;
    dagc_link_s st_nxt;
    logic       fresh_r;

    // marks the first edge after a select; set by chip select itself since the clock may be parked
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            fresh_r <= 1'b1;
        else
            fresh_r <= 1'b0;
    end

    // shift on rising edge, count stops at 16 so extra clocks cannot corrupt the frame
    always_comb
    begin
        st_nxt = st_r;
        if (!cs_n)
        begin
            if (fresh_r)
            begin
                st_nxt.shift = dagc_frame_s'({st_r.shift[14:0], sdi});
                st_nxt.cnt   = 5'h01;
            end
            else if (st_r.cnt != FRAME_BITS)
            begin
                st_nxt.shift = dagc_frame_s'({st_r.shift[14:0], sdi});
                st_nxt.cnt   = 5'(st_r.cnt + 5'h01);
            end
            if (st_nxt.cnt == BYTE_BITS && st_r.cnt != BYTE_BITS)
                st_nxt.addr = st_nxt.shift[ADDR_W-1:0];
            if (st_nxt.cnt == FRAME_BITS && st_r.cnt != FRAME_BITS)
                st_nxt.toggle = ~st_r.toggle;
        end
    end

    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // output changes on falling edges 8..15, msb first; cleared whenever deselected
    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
            sdo_bit <= 1'b0;
        else if (st_r.cnt >= BYTE_BITS && st_r.cnt <= LAST_IDX)
            sdo_bit <= rd_byte[3'(4'hF - st_r.cnt[3:0])];
        else
            sdo_bit <= 1'b0;
    end

    assign rd_addr = st_r.addr;
    assign xfer    = '{frame: st_r.shift, toggle: st_r.toggle};

    // the sixteenth rising edge of a frame flips the completion toggle
    property frame_toggle_p;
        @(posedge sclk) disable iff (rst)
        (!cs_n && !fresh_r && st_r.cnt == LAST_IDX) |=> (st_r.toggle != $past(st_r.toggle));
    endproperty
    chk_frame_toggle_flip: assert property (frame_toggle_p)
        else $error("sixteenth clock did not complete the frame");

endmodule

// File: design/dagc_port.sv
// top of the gain control port: mode select, parallel path, register file and commit logic
`timescale 1ns/10ps
module dagc_port
    import dagc_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'hA5, // arbitrary value
    parameter logic [7:0] PART_CODE     = 8'h5A  // arbitrary value
)
(
    // core clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // mode and power pins
    input  wire logic       serial_sel,
    input  wire logic       amp_shutdown_in,
    // gain code pins, bits 0..3 shared with the serial link
    input  wire logic       gain_code_bit0,
    input  wire logic       gain_code_bit1,
    input  wire logic       gain_code_bit2,
    input  wire logic       gain_code_bit3,
    input  wire logic       gain_code_bit4,
    input  wire logic       gain_code_bit5,
    input  wire logic       gain_code_bit6,
    // serial clock, same pin as gain_code_bit2
    input  wire logic       link_sclk,
    // serial data out on the gain_code_bit0 pin
    output logic            serial_out,
    output logic            serial_out_oe,
    // amplifier control
    output logic [6:0]      chan_a_gain_qdb,
    output logic [6:0]      chan_b_gain_qdb,
    output logic            chan_a_en,
    output logic            chan_b_en,
    output logic            serial_mode
);

    dagc_core_s        st_r;
    dagc_core_s        st_nxt;
    dagc_xfer_s        xfer;
    dagc_frame_s       frm;
    logic [ADDR_W-1:0] link_addr;
    logic [7:0]        rd_byte;
    logic              sdo_bit;
    logic [6:0]        par_code;
    logic              link_cs_n;
    logic              commit;

    // code to gain in quarter dB above zero, floored at 6 dB
    function automatic logic [6:0] gain_qdb(input logic [6:0] code);
        if (code > GAIN_CODE_MAX)
            return GAIN_QDB_FLOOR;
        return 7'(GAIN_QDB_TOP - code);
    endfunction

    // read decode; identity codes are constants, reserved bits read zero
    function automatic logic [7:0] reg_read(input logic [ADDR_W-1:0] a, input dagc_core_s s);
        case (a)
            ADDR_REVISION: return REVISION_CODE;
            ADDR_PART:     return PART_CODE;
            ADDR_POWER:    return s.pwr;
            ADDR_GAIN_A:   return s.gain_a;
            ADDR_GAIN_B:   return s.gain_b;
            ADDR_CTRL:     return s.ctrl;
            default:       return 8'h00;
        endcase
    endfunction

    // pin groups
    assign par_code  = {gain_code_bit6, gain_code_bit5, gain_code_bit4, gain_code_bit3,
                        gain_code_bit2, gain_code_bit1, gain_code_bit0};
    assign link_cs_n = gain_code_bit3;
    assign frm       = xfer.frame;

    // register file is only written between frames, so the link may read it without a crossing
    assign rd_byte = reg_read(link_addr, st_r);

    dagc_link u_link (
        .sclk    (link_sclk),
        .rst     (rst),
        .cs_n    (link_cs_n),
        .sdi     (gain_code_bit1),
        .rd_byte (rd_byte),
        .rd_addr (link_addr),
        .xfer    (xfer),
        .sdo_bit (sdo_bit)
    );

    // a completed frame is committed once chip select is seen high again
    assign commit = st_r.pend && st_r.cs2;

    // next state of the core
    always_comb
    begin
        st_nxt = st_r;
        // two flop synchronisers for pins and the link toggle
        st_nxt.sel1 = serial_sel;
        st_nxt.sel2 = st_r.sel1;
        st_nxt.sd1  = amp_shutdown_in;
        st_nxt.sd2  = st_r.sd1;
        st_nxt.cs1  = link_cs_n;
        st_nxt.cs2  = st_r.cs1;
        st_nxt.tg1  = xfer.toggle;
        st_nxt.tg2  = st_r.tg1;

        // frame commit; a frame cut short never flips the toggle and so never lands here
        if (commit)
        begin
            st_nxt.pend = 1'b0;
            if (st_r.sel2 && !frm.read_not_write)
            begin
                case (frm.addr)
                    ADDR_POWER:  st_nxt.pwr    = frm.data & PWR_MASK;
                    ADDR_GAIN_A: st_nxt.gain_a = frm.data & GAIN_MASK;
                    ADDR_GAIN_B: st_nxt.gain_b = frm.data & GAIN_MASK;
                    ADDR_CTRL:   st_nxt.ctrl   = frm.data & CTRL_MASK;
                    default:     st_nxt.pend   = 1'b0; // identity and unmapped: no effect
                endcase
            end
        end
        // a new completion beats the clear in the same cycle
        if (st_r.tg2 != st_r.tg_seen)
        begin
            st_nxt.tg_seen = st_r.tg2;
            st_nxt.pend    = 1'b1;
        end

        // channel gain follows its register only while its load bit is set
        if (st_r.ctrl[LOAD_A_BIT])
            st_nxt.act_a = st_r.gain_a[6:0];
        if (st_r.ctrl[LOAD_B_BIT])
            st_nxt.act_b = st_r.ctrl[TIE_BIT] ? st_r.gain_a[6:0] : st_r.gain_b[6:0];

        // power: register in serial mode, shutdown pin in parallel mode
        if (st_r.sel2)
        begin
            st_nxt.en_a = !(st_r.pwr[PD_A_FIRST] | st_r.pwr[PD_A_SECOND]);
            st_nxt.en_b = !(st_r.pwr[PD_B_FIRST] | st_r.pwr[PD_B_SECOND]);
        end
        else
        begin
            st_nxt.en_a = !st_r.sd2;
            st_nxt.en_b = !st_r.sd2;
        end
    end

    // single state register; reset loads the documented defaults
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            st_r <= CORE_RST;
        else
            st_r <= st_nxt;
    end

    // gain outputs: parallel code goes straight through, serial uses the applied registers
    always_comb
    begin
        if (st_r.sel2)
        begin
            chan_a_gain_qdb = gain_qdb(st_r.act_a);
            chan_b_gain_qdb = gain_qdb(st_r.act_b);
        end
        else
        begin
            chan_a_gain_qdb = gain_qdb(par_code);
            chan_b_gain_qdb = gain_qdb(par_code);
        end
    end

    // gain is independent of shutdown, so it survives a disabled period
    assign chan_a_en   = st_r.en_a;
    assign chan_b_en   = st_r.en_b;
    assign serial_mode = st_r.sel2;

    // current source output: on only for a one, and only while selected in serial mode
    assign serial_out    = sdo_bit;
    assign serial_out_oe = st_r.sel2 && !link_cs_n && sdo_bit;

    // ---- checks ----

    sequence commit_gain_a_s;
        commit && st_r.sel2 && !frm.read_not_write && frm.addr == ADDR_GAIN_A;
    endsequence

    sequence commit_ident_s;
        commit && st_r.sel2 && (frm.addr == ADDR_REVISION || frm.addr == ADDR_PART);
    endsequence

    sequence shut_held_s;
        (!st_r.sel2 && st_r.sd2) [*2];
    endsequence

    chk_par_gain_floor: assert property (@(posedge sys_clk) disable iff (rst)
        (!st_r.sel2 && par_code > GAIN_CODE_MAX) |-> (chan_a_gain_qdb == GAIN_QDB_FLOOR
                                                      && chan_b_gain_qdb == GAIN_QDB_FLOOR))
        else $error("parallel gain not floored at 6 dB");

    chk_par_gain_direct: assert property (@(posedge sys_clk) disable iff (rst)
        (!st_r.sel2 && par_code <= GAIN_CODE_MAX) |-> (7'(chan_a_gain_qdb + par_code) == GAIN_QDB_TOP))
        else $error("parallel gain does not track pins in the same cycle");

    chk_par_shut_off: assert property (@(posedge sys_clk) disable iff (rst)
        shut_held_s |=> (!chan_a_en && !chan_b_en))
        else $error("shutdown high did not disable the amplifier");

    chk_shut_keeps_gain: assert property (@(posedge sys_clk) disable iff (rst)
        (!st_r.sel2 && !$past(st_r.sel2) && $changed(st_r.sd2) && $stable(par_code))
        |-> $stable(chan_a_gain_qdb))
        else $error("shutdown disturbed the gain setting");

    chk_serial_power: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.sel2 && $past(st_r.sel2)) |->
        (chan_a_en == !($past(st_r.pwr[PD_A_FIRST]) | $past(st_r.pwr[PD_A_SECOND]))
         && chan_b_en == !($past(st_r.pwr[PD_B_FIRST]) | $past(st_r.pwr[PD_B_SECOND]))))
        else $error("serial power state not taken from register");

    chk_gain_a_write: assert property (@(posedge sys_clk) disable iff (rst)
        commit_gain_a_s |=> (st_r.gain_a == ($past(frm.data) & GAIN_MASK)))
        else $error("committed write did not reach gain register A");

    chk_short_frame: assert property (@(posedge sys_clk) disable iff (rst)
        (!st_r.pend && st_r.tg2 == st_r.tg_seen) |=>
        ($stable(st_r.pwr) && $stable(st_r.gain_a) && $stable(st_r.gain_b) && $stable(st_r.ctrl)))
        else $error("register changed without a completed frame");

    chk_ident_ro: assert property (@(posedge sys_clk) disable iff (rst)
        commit_ident_s |=> ($stable(st_r.pwr) && $stable(st_r.gain_a) && $stable(st_r.ctrl)))
        else $error("write to identity address changed a register");

    chk_reset_values: assert property (@(posedge sys_clk) disable iff (rst)
        $past(rst) |-> (st_r.pwr == PWR_RST && st_r.gain_a == GAIN_RST
                        && st_r.gain_b == GAIN_RST && st_r.ctrl == CTRL_RST))
        else $error("register defaults wrong after reset");

    chk_tie_follow: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.ctrl[LOAD_B_BIT] && st_r.ctrl[TIE_BIT]) |=> (st_r.act_b == $past(st_r.gain_a[6:0])))
        else $error("tied channel B did not follow register A");

    chk_load_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (!st_r.ctrl[LOAD_A_BIT]) |=> $stable(st_r.act_a))
        else $error("channel A gain moved with load bit clear");

    chk_sdo_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        link_cs_n |-> !serial_out_oe)
        else $error("serial output driven while deselected");

    chk_serial_ignores_pins: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r.sel2 && $stable(st_r.sel2) && $stable(st_r.act_a) && $changed(par_code))
        |-> $stable(chan_a_gain_qdb))
        else $error("serial mode gain moved with parallel pins");

endmodule

// File: tb/dagc_host.sv
// host side serial controller model that drives the shared link pins
`timescale 1ns/10ps
module dagc_host
(
    // link pins
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo
);
    // link clock parked low outside frames
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // one access of nbits clocks at a 6 ns period; rd gathers the second byte
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
        rd   = 8'h00;
        cs_n = 1'b0;
        #5;
        for (int i = 0; i < nbits; i++)
        begin
            sdi = word[15 - i];
            #3;
            if (i >= 8)
                rd[15 - i] = sdo;
            sclk = 1'b1;
            #3;
            sclk = 1'b0; // no runt pulse when stopping
        end
        sdi = ~sdi; // released line must not keep a stale bit
        #5;
        cs_n = 1'b1;
        #100; // idle gap lets the core commit the frozen frame
    endtask
endmodule

// File: tb/dagc_port_tb.sv
// self checking bench for the dual amplifier gain control port
`timescale 1ns/10ps
module dagc_port_tb;
    import dagc_pkg::*;
    logic       sys_clk;
    logic       rst;
    logic       serial_sel;
    logic       amp_shutdown_in;
    logic [6:0] par;
    logic       h_sclk;
    logic       h_cs_n;
    logic       h_sdi;
    logic       sdo_wire;
    wire        b0, b1, b2, b3;
    wire logic  serial_out, serial_out_oe, chan_a_en, chan_b_en, serial_mode;
    wire [6:0]  qa, qb;
    int         bad_count, n_checks, seed;
    logic [7:0] rd;
    logic [6:0] g;

    // pull-down on the output pin; the source only drives ones
    assign sdo_wire = serial_out_oe ? 1'b1 : 1'b0;
    assign b0 = serial_sel ? sdo_wire : par[0];
    assign b1 = serial_sel ? h_sdi : par[1];
    assign b2 = serial_sel ? h_sclk : par[2];
    assign b3 = serial_sel ? h_cs_n : par[3];

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    dagc_port dut (.sys_clk(sys_clk), .rst(rst), .serial_sel(serial_sel), .amp_shutdown_in(amp_shutdown_in),
        .gain_code_bit0(b0), .gain_code_bit1(b1), .gain_code_bit2(b2), .gain_code_bit3(b3),
        .gain_code_bit4(par[4]), .gain_code_bit5(par[5]), .gain_code_bit6(par[6]), .link_sclk(b2),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .chan_a_gain_qdb(qa),
        .chan_b_gain_qdb(qb), .chan_a_en(chan_a_en), .chan_b_en(chan_b_en), .serial_mode(serial_mode));

    dagc_host host (.sclk(h_sclk), .cs_n(h_cs_n), .sdi(h_sdi), .sdo(sdo_wire));

    // expected gain in quarter dB for a parallel pin code
    function automatic logic [7:0] par_qdb(input logic [6:0] c);
        return {1'b0, (c > GAIN_CODE_MAX) ? GAIN_QDB_FLOOR : GAIN_QDB_TOP - c};
    endfunction

    // register contents right after reset
    function automatic logic [7:0] rst_val(input int a);
        case (a)
            0: return dut.REVISION_CODE;
            1: return dut.PART_CODE;
            2: return PWR_RST;
            3, 4: return GAIN_RST;
            5: return CTRL_RST;
            default: return 8'h00;
        endcase
    endfunction

    task automatic chk_val(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.xfer({1'b0, 3'h0, a, d}, 16, rd);
    endtask

    // read frames carry random data, which must be ignored
    task automatic rdreg(input logic [3:0] a);
        host.xfer({1'b1, 3'h0, a, 8'($random(seed))}, 16, rd);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog cuts a hang short
    initial
    begin
        repeat (50000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end

    initial
    begin
        seed = 16;
        bad_count = 0;
        n_checks = 0;
        rst = 1'b1;
        serial_sel = 1'b0;
        amp_shutdown_in = 1'b0;
        par = 7'h00;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        // parallel codes: table corners then random, all pins switched at once
        for (int i = 0; i < 30; i++)
        begin
            @(posedge sys_clk);
            par <= (i == 0) ? 7'h00 : (i == 1) ? 7'h50 : (i == 2) ? 7'h51 : (i == 3) ? 7'h7F
                   : 7'($random(seed));
            #1;
            chk_val("par gain a", par_qdb(par), {1'b0, qa});
            chk_val("par gain b", par_qdb(par), {1'b0, qb});
        end
        // shutdown drops the channels but keeps the gain
        @(posedge sys_clk);
        amp_shutdown_in <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk_bit("sd en a", 1'b0, chan_a_en);
        chk_bit("sd en b", 1'b0, chan_b_en);
        chk_val("sd gain", par_qdb(par), {1'b0, qa});
        amp_shutdown_in <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk_bit("on en a", 1'b1, chan_a_en);
        // serial mode; shutdown pin and remaining code pins must be ignored
        serial_sel <= 1'b1;
        amp_shutdown_in <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk_bit("mode", 1'b1, serial_mode);
        chk_bit("oe idle", 1'b0, serial_out_oe);
        chk_bit("sd ignored", 1'b1, chan_a_en);
        chk_val("ser gain rst", {1'b0, GAIN_QDB_FLOOR}, {1'b0, qa});
        for (int a = 0; a < 7; a++)
        begin
            rdreg(4'(a));
            chk_val("reset reg", rst_val(a), rd);
            chk_bit("sdo idle", 1'b0, serial_out);
        end
        wr(4'h0, 8'hFF);
        rdreg(4'h0);
        chk_val("ro reg", dut.REVISION_CODE, rd);
        // random gain writes with loads enabled; bit 7 reads back zero
        for (int i = 0; i < 8; i++)
        begin
            g = 7'(($random(seed) & 32'h7FFF_FFFF) % 81);
            wr(4'h3, {1'b1, g});
            rdreg(4'h3);
            chk_val("gain a reg", {1'b0, g}, rd);
            chk_val("gain a out", {1'b0, GAIN_QDB_TOP - g}, {1'b0, qa});
            chk_val("gain b hold", {1'b0, GAIN_QDB_FLOOR}, {1'b0, qb});
        end
        // aborted frame leaves the register alone
        host.xfer({1'b0, 3'h0, 4'h3, 8'h11}, 10, rd);
        rdreg(4'h3);
        chk_val("abort", {1'b0, g}, rd);
        // load bits clear: register changes, output does not
        wr(4'h5, 8'h00);
        wr(4'h3, 8'h05);
        chk_val("no load", {1'b0, GAIN_QDB_TOP - g}, {1'b0, qa});
        // tie bit: channel b follows register a
        wr(4'h5, 8'h07);
        wr(4'h3, 8'h20);
        chk_val("tie a", 8'h48, {1'b0, qa});
        chk_val("tie b", 8'h48, {1'b0, qb});
        // each power bit turns off only its own channel
        for (int b = 2; b < 6; b++)
        begin
            wr(4'h2, 8'(1 << b));
            rdreg(4'h2);
            chk_val("pwr reg", 8'(1 << b), rd);
            chk_bit("pwr a", !(b == 5 || b == 3), chan_a_en);
            chk_bit("pwr b", !(b == 4 || b == 2), chan_b_en);
        end
        complete_run();
    end
endmodule
